/* verilog/stseq_sequencer.sv */
// What this block does
// R1: Module match is high only when all three byte matches are high.
// R2: Stack match is module match ANDed with every expansion match.
// R3: Polarity bit high counts matches, low counts absences.
// R4: Storage inhibited blocks recognition from the occurrence counter.
// R5: Init clears trigger latch; gate high sets it until acquisition stops.
// R6: Control RAM per level: last, timer, pulse, polarity bits.
// R7: Four-bit level pointer advanced by level clock, forwarded out.
// R8: Manual step enable low plus step toggle advances pointer once.
// R9: Pointer does not count while last level is flagged.
// R10: Restart clears pointer; load strobe parallel-loads it.
// R11: Restart ignored in paired mode or with stack/qualifier match.
// R12: Restart acts only while storage is enabled.
// R13: Restart clears pointer then pulses occurrence reload next cycle.
// R14: Restart pulse clears counter/timer unless clear enable masks it.
// R15: Any clear raises readable cleared flag; preset returns it idle.
// R16: Qualifier trigger word latched only while storage enabled.
// R17: Sequence trigger captured at last level on level increment.
// R18: Trigger inhibit low holds sequence trigger latch inactive.
// R19: Two trigger sources ORed, delayed two cycles, driven out.
// R20: Hold output driven low while module owns trigger path.
// R21: Output disable low releases event and hold outputs.
// R22: Pulse-flag level latched on increment drives sync pulse.
// R23: Occurrence counter is 12-bit, preloaded with complement count.
// R24: At all ones, advance level and reload from next entry.
// R25: Restart reload pulse lasts one clock cycle.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "stseq_consts.svh"

module stseq_sequencer #(
	parameter int OCC_W = `STSEQ_OCC_W,
	parameter int CT_W  = `STSEQ_CT_W
)(
	// Clock and reset.
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Byte recognizers and expansion stack.
	input  wire logic [2:0]            byte_match,
	input  wire logic                  expansion_match,
	output logic                       module_match_out,
	output logic                       level_advance_clock,
	// Control RAM load port.
	input  wire logic                  ctl_wr,
	input  wire stseq_pkg::stseq_ptr_t ctl_addr,
	input  wire stseq_pkg::stseq_ctl_t ctl_wdata,
	input  wire logic                  occ_wr,
	input  wire stseq_pkg::stseq_occ_t occ_wdata,
	// Controller lines.
	input  wire logic                  module_init,
	input  wire logic                  store_enable_n,
	input  wire logic                  external_trigger_gate,
	input  wire logic                  acquisition_stop,
	input  wire logic                  manual_step_enable_n,
	input  wire logic                  manual_step_clock,
	input  wire logic                  level_pointer_load,
	input  wire stseq_pkg::stseq_ptr_t level_pointer_value,
	input  wire logic                  restart_word,
	input  wire logic                  paired_qualifier_mode,
	input  wire logic                  qualifier_trigger_word,
	input  wire logic                  counter_clear_enable,
	input  wire logic                  cleared_flag_preset,
	input  wire logic                  trigger_inhibit_n,
	input  wire logic                  trigger_output_disable_n,
	// Status and trigger outputs.
	output stseq_pkg::stseq_ptr_t      level_pointer,
	output logic                       timer_action,
	output logic                       occurrence_reload_after_clear,
	output logic                       counter_clear,
	output logic                       counter_cleared_flag,
	output logic                       trigger_event_out,
	output logic                       trigger_event_oe,
	output logic                       acquisition_hold_out,
	output logic                       acquisition_hold_oe,
	output logic                       sync_pulse_out
);
	import stseq_pkg::*;

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	stseq_ctl_t         ctl_mem_ff [`STSEQ_LEVELS];
	logic [OCC_W-1:0]   occ_mem_ff [`STSEQ_LEVELS];
	logic [OCC_W-1:0]   occ_cnt_ff;
	stseq_ptr_t         ptr_ff;
	logic               recog_permit_ff;
	logic               step_s1_ff;
	logic               step_s2_ff;
	logic               step_s3_ff;
	logic               step_lvl_ff;
	logic               adv_ff;
	logic               reload_ff;
	logic               seq_trig_ff;
	logic               qual_trig_ff;
	logic [`STSEQ_TRIG_DLY-1:0] trig_dly_ff;
	logic               flag_ff;
	logic               clr_ff;
	logic               sync_ff;
	logic               mm_ff;
	logic               oe_ff;
	logic               timer_ff;

	// ----------------------------------------------------------------
	// Combinational decode
	// ----------------------------------------------------------------
	stseq_ctl_t cur_ctl;
	stseq_ptr_t nxt_ptr;
	logic       last_level_n;
	logic       level_pulse_flag;
	logic       match_polarity_select;
	logic       module_match;
	logic       stack_match;
	logic       count_event;
	logic       restart_ok;
	logic       manual_step;
	logic       occ_full;
	logic       ptr_step;

	// Current level's action bits.
	assign cur_ctl               = ctl_mem_ff[ptr_ff];
	assign last_level_n          = cur_ctl[`STSEQ_CB_LAST_N];
	assign level_pulse_flag      = cur_ctl[`STSEQ_CB_PULSE];
	assign match_polarity_select = cur_ctl[`STSEQ_CB_POL];

	// Word match across bytes and the expansion stack.
	assign module_match = &byte_match; // R1
	assign stack_match  = module_match & expansion_match; // R2

	// Polarity, storage gate and trigger latch qualify the count.
	assign count_event = (match_polarity_select ? stack_match
		: ~stack_match) // R3
		& ~store_enable_n // R4
		& recog_permit_ff; // R5

	// Restart accepted only when not shadowed and storage is active.
	assign restart_ok = restart_word & ~paired_qualifier_mode
		& ~stack_match & ~qualifier_trigger_word // R11
		& ~store_enable_n; // R12

	// Manual step: a toggle seen after the synchroniser settles.
	assign manual_step = ~manual_step_enable_n
		& (step_s2_ff == step_s3_ff) & (step_s3_ff != step_lvl_ff); // R8
	assign occ_full    = (occ_cnt_ff == OCC_W'(`STSEQ_OCC_FULL));
	assign ptr_step    = (adv_ff | manual_step) & last_level_n; // R9
	// Level after this edge, so a reload fetches the level being entered.
	assign nxt_ptr = restart_ok ? `STSEQ_PTR_ZERO : level_pointer_load
		? level_pointer_value : ptr_step ? ptr_ff + 1'b1 : ptr_ff; // R24

	// ----------------------------------------------------------------
	// Control and occurrence RAM loading
	// ----------------------------------------------------------------
	// Controller writes action bits and preload counts per level.
	always_ff @(posedge clk)
	begin
		if (ctl_wr)
		begin
			ctl_mem_ff[ctl_addr] <= ctl_wdata; // R6
		end
		if (occ_wr)
		begin
			occ_mem_ff[ctl_addr] <= occ_wdata; // R23
		end
	end

	// ----------------------------------------------------------------
	// External trigger latch
	// ----------------------------------------------------------------
	// Cleared by init; set by the gate until acquisition stops.
	always_ff @(posedge clk)
	begin
		if (!rst_n || module_init || acquisition_stop)
		begin
			recog_permit_ff <= 1'b0; // R5
		end
		else if (external_trigger_gate)
		begin
			recog_permit_ff <= 1'b1; // R5
		end
	end

	// ----------------------------------------------------------------
	// Manual step synchroniser
	// ----------------------------------------------------------------
	// Three stages; a toggle counts once stages two and three agree.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			step_s1_ff <= 1'b0;
			step_s2_ff <= 1'b0;
			step_s3_ff <= 1'b0;
			step_lvl_ff <= 1'b0;
		end
		else
		begin
			step_s1_ff <= manual_step_clock;
			step_s2_ff <= step_s1_ff;
			step_s3_ff <= step_s2_ff;
			step_lvl_ff <= (step_s2_ff == step_s3_ff) ? step_s3_ff : step_lvl_ff;
		end
	end

	// ----------------------------------------------------------------
	// Occurrence counter
	// ----------------------------------------------------------------
	// Counts qualified events; at all ones raises the level clock.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			occ_cnt_ff <= '0;
			adv_ff     <= 1'b0;
		end
		else if (reload_ff || adv_ff || level_pointer_load)
		begin
			occ_cnt_ff <= occ_mem_ff[nxt_ptr]; // R24
			adv_ff     <= 1'b0;
		end
		else if (occ_full)
		begin
			adv_ff <= 1'b1; // R24
		end
		else if (count_event)
		begin
			occ_cnt_ff <= occ_cnt_ff + 1'b1; // R23
		end
	end

	// ----------------------------------------------------------------
	// Level pointer
	// ----------------------------------------------------------------
	// Restart clears, load strobe loads, steps count up.
	always_ff @(posedge clk)
	begin
		if (!rst_n || restart_ok)
		begin
			ptr_ff <= `STSEQ_PTR_ZERO; // R10 R13
		end
		else if (level_pointer_load)
		begin
			ptr_ff <= level_pointer_value; // R10
		end
		else if (ptr_step)
		begin
			ptr_ff <= ptr_ff + 1'b1; // R7
		end
	end

	// ----------------------------------------------------------------
	// Restart reload and counter/timer clear
	// ----------------------------------------------------------------
	// One-cycle reload pulse on the edge after an accepted restart.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			reload_ff <= 1'b0;
			clr_ff    <= 1'b0;
		end
		else
		begin
			reload_ff <= restart_ok; // R13 R25
			clr_ff    <= restart_ok & counter_clear_enable; // R14
		end
	end

	// Cleared flag rises on any clear; preset returns it to idle.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			flag_ff <= 1'b0;
		end
		else if (clr_ff)
		begin
			flag_ff <= 1'b1; // R15
		end
		else if (cleared_flag_preset)
		begin
			flag_ff <= 1'b0; // R15
		end
	end

	// ----------------------------------------------------------------
	// Trigger sources and delay
	// ----------------------------------------------------------------
	// Qualifier trigger is sticky until init; sequence trigger also clears while inhibit is low.
	always_ff @(posedge clk)
	begin
		if (!rst_n || module_init)
		begin
			seq_trig_ff  <= 1'b0;
			qual_trig_ff <= 1'b0;
		end
		else
		begin
			if (!trigger_inhibit_n)
			begin
				seq_trig_ff <= 1'b0; // R18
			end
			else if (adv_ff && !last_level_n)
			begin
				seq_trig_ff <= 1'b1; // R17
			end
			if (qualifier_trigger_word && !store_enable_n)
			begin
				qual_trig_ff <= 1'b1; // R16
			end
		end
	end

	// Two-stage delay of the ORed trigger.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			trig_dly_ff <= '0;
		end
		else
		begin
			trig_dly_ff <= {trig_dly_ff[0], seq_trig_ff | qual_trig_ff}; // R19
		end
	end

	// ----------------------------------------------------------------
	// Sync pulse, output enables and registered status
	// ----------------------------------------------------------------
	// Sync pulse on a level increment out of a pulse-flag level.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync_ff  <= 1'b0;
			mm_ff    <= 1'b0;
			oe_ff    <= 1'b0;
			timer_ff <= 1'b0;
		end
		else
		begin
			sync_ff  <= adv_ff & level_pulse_flag; // R22
			mm_ff    <= module_match;
			oe_ff    <= trigger_output_disable_n; // R21
			timer_ff <= cur_ctl[`STSEQ_CB_TIMER];
		end
	end

	// Output drives.
	assign module_match_out              = mm_ff;
	assign level_advance_clock           = adv_ff; // R7
	assign level_pointer                 = ptr_ff;
	assign timer_action                  = timer_ff;
	assign occurrence_reload_after_clear = reload_ff;
	assign counter_clear                 = clr_ff;
	assign counter_cleared_flag          = flag_ff;
	assign trigger_event_out             = trig_dly_ff[1];
	assign trigger_event_oe              = oe_ff;
	assign acquisition_hold_out          = 1'b0; // R20
	assign acquisition_hold_oe           = oe_ff; // R20 R21
	assign sync_pulse_out                = sync_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_restart;
		restart_ok;
	endsequence

	a_reload_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		s_restart ##1 1'b1 |-> reload_ff) // R13
		else $error("reload pulse missing after restart");
	a_reload_width: assert property (@(posedge clk) disable iff (!rst_n)
		reload_ff && !$past(restart_ok,2) |=> !reload_ff || restart_ok) // R25
		else $error("reload pulse too wide");
	a_ptr_clear: assert property (@(posedge clk) disable iff (!rst_n)
		restart_ok |=> ptr_ff == `STSEQ_PTR_ZERO) // R10
		else $error("pointer not cleared by restart");
	a_no_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		!last_level_n && !restart_ok && !level_pointer_load
		|=> $stable(ptr_ff)) // R9
		else $error("pointer moved at last level");
	a_trig_delay: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(seq_trig_ff | qual_trig_ff) |-> ##2 trigger_event_out) // R19
		else $error("trigger delay wrong");
	a_inhibit_seq: assert property (@(posedge clk) disable iff (!rst_n)
		!trigger_inhibit_n |=> !seq_trig_ff) // R18
		else $error("sequence trigger under inhibit");
	a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		clr_ff |=> counter_cleared_flag) // R15
		else $error("cleared flag not raised");
	a_count_gate: assert property (@(posedge clk) disable iff (!rst_n)
		store_enable_n && !reload_ff && !adv_ff && !level_pointer_load
		|=> $stable(occ_cnt_ff)) // R4
		else $error("counter moved while storage inhibited");
	a_clear_mask: assert property (@(posedge clk) disable iff (!rst_n)
		restart_ok && !counter_clear_enable |=> !counter_clear) // R14
		else $error("masked clear leaked");
	a_match_all: assert property (@(posedge clk) disable iff (!rst_n)
		byte_match != 3'h7 |=> !module_match_out) // R1
		else $error("module match without all bytes");
endmodule

/* include/stseq_consts.svh */
// Constants for the sequential trigger sequencer.
`ifndef STSEQ_CONSTS_SVH
`define STSEQ_CONSTS_SVH
`define STSEQ_LEVELS      16
`define STSEQ_PTR_W       4
`define STSEQ_OCC_W       12
`define STSEQ_OCC_FULL    12'hFFF
`define STSEQ_PTR_ZERO    4'h0
`define STSEQ_TRIG_DLY    2
`define STSEQ_CT_W        16
`define STSEQ_CT_ZERO     16'h0000
// Control word bit positions.
`define STSEQ_CB_LAST_N   0
`define STSEQ_CB_TIMER    1
`define STSEQ_CB_PULSE    2
`define STSEQ_CB_POL      3
`endif

/* include/stseq_pkg.sv */
// Types shared by the sequential trigger sequencer.
package stseq_pkg;
	typedef logic [3:0]  stseq_ptr_t;
	typedef logic [3:0]  stseq_ctl_t;
	typedef logic [11:0] stseq_occ_t;
	typedef enum logic [1:0] {STSEQ_RUN, STSEQ_RELOAD, STSEQ_IDLE} stseq_occ_e;
endpackage

/* test/stseq_far_side.sv */
// Far-side model: time-base event lines and the expansion stack.
`timescale 1ns/10ps
//------------------------------------------------------------
// Far side
//------------------------------------------------------------
module stseq_far_side (
	// Clock.
	input  wire logic clk,
	// Drivers of this module.
	input  wire logic event_drv,
	input  wire logic event_oe,
	input  wire logic hold_drv,
	input  wire logic hold_oe,
	input  wire logic own_match,
	// Resolved lines.
	output logic      event_line,
	output logic      hold_line,
	output logic      expansion_match
);
	logic other_ff = 1'h0;

	// Another module toggles the lines every cycle once ours let go.
	always @(posedge clk)
	begin
		other_ff <= ~other_ff;
	end

	// A released line follows the other driver, never our last value.
	assign event_line = event_oe ? event_drv : other_ff;
	assign hold_line  = hold_oe ? hold_drv : ~other_ff;
	// The stack match is this module's own vote alone.
	assign expansion_match = own_match;
endmodule

/* test/stseq_sequencer_bench.sv */
// Self-checking bench for the sequential trigger sequencer.
`timescale 1ns/10ps
//------------------------------------------------------------
// Bench top
//------------------------------------------------------------
module stseq_sequencer_bench;
	import stseq_pkg::*;
	// Design inputs, idle at time zero.
	logic       clk = 1'h0, rst_n = 1'h0, own_match = 1'h1;
	logic [2:0] byte_match = 3'h0;
	logic       ctl_wr = 1'h0, occ_wr = 1'h0, module_init = 1'h0;
	stseq_ptr_t ctl_addr = 4'h0, level_pointer_value = 4'h0;
	stseq_ctl_t ctl_wdata = 4'h0;
	stseq_occ_t occ_wdata = 12'h000;
	logic       store_enable_n = 1'h1, external_trigger_gate = 1'h0;
	logic       acquisition_stop = 1'h0, manual_step_enable_n = 1'h1;
	logic       manual_step_clock = 1'h0, level_pointer_load = 1'h0;
	logic       restart_word = 1'h0, paired_qualifier_mode = 1'h0;
	logic       qualifier_trigger_word = 1'h0, counter_clear_enable = 1'h1;
	logic       cleared_flag_preset = 1'h0, trigger_inhibit_n = 1'h1;
	logic       trigger_output_disable_n = 1'h1;
	// Design and far-side outputs.
	logic       module_match_out, level_advance_clock, timer_action;
	logic       occurrence_reload_after_clear, counter_clear, sync_pulse_out;
	logic       counter_cleared_flag, trigger_event_out, trigger_event_oe;
	logic       acquisition_hold_out, acquisition_hold_oe, expansion_match;
	logic       event_line, hold_line;
	stseq_ptr_t level_pointer;
	int         n_errors = 0, n_checks = 0, n_cyc = 0;
	int         n_adv = 0, n_sync = 0, n_rel = 0, n_clr = 0;

	stseq_sequencer dut (
		.clk, .rst_n, .byte_match, .expansion_match, .module_match_out,
		.level_advance_clock, .ctl_wr, .ctl_addr, .ctl_wdata, .occ_wr,
		.occ_wdata, .module_init, .store_enable_n, .external_trigger_gate,
		.acquisition_stop, .manual_step_enable_n, .manual_step_clock,
		.level_pointer_load, .level_pointer_value, .restart_word,
		.paired_qualifier_mode, .qualifier_trigger_word,
		.counter_clear_enable, .cleared_flag_preset, .trigger_inhibit_n,
		.trigger_output_disable_n, .level_pointer, .timer_action,
		.occurrence_reload_after_clear, .counter_clear,
		.counter_cleared_flag, .trigger_event_out, .trigger_event_oe,
		.acquisition_hold_out, .acquisition_hold_oe, .sync_pulse_out
	);
	stseq_far_side far (
		.clk, .event_drv(trigger_event_out), .event_oe(trigger_event_oe),
		.hold_drv(acquisition_hold_out), .hold_oe(acquisition_hold_oe),
		.own_match, .event_line, .hold_line, .expansion_match
	);

	// Free-running 50 MHz clock.
	initial
	begin
		forever #10 clk = ~clk;
	end

	// Pulses are counted at the falling edge, once they have settled.
	always @(negedge clk)
	begin
		n_adv += (level_advance_clock === 1'h1);
		n_sync += (sync_pulse_out === 1'h1);
		n_rel += (occurrence_reload_after_clear === 1'h1);
		n_clr += (counter_clear === 1'h1);
	end

	// A hung run is cut short well past the expected length.
	always @(posedge clk)
	begin
		n_cyc++;
		if (n_cyc == 3000)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic bit_is(input logic got, input logic exp);
	begin
		cmp({15'h0000, got}, {15'h0000, exp});
	end
	endtask

	task automatic ptr_is(input stseq_ptr_t got, input stseq_ptr_t exp);
	begin
		cmp({12'h000, got}, {12'h000, exp});
	end
	endtask

	task automatic cnt_is(input int got, input int exp);
	begin
		cmp(got[15:0], exp[15:0]);
	end
	endtask

	// Waits k edges after a drive and stops where outputs are settled.
	task automatic settle(input int k);
	begin
		repeat (k) @(posedge clk);
		@(negedge clk);
	end
	endtask

	task automatic load(input stseq_ptr_t a, input stseq_ctl_t c,
		input stseq_occ_t o);
	begin
		@(posedge clk);
		ctl_wr    <= 1'h1;
		occ_wr    <= 1'h1;
		ctl_addr  <= a;
		ctl_wdata <= c;
		occ_wdata <= o;
	end
	endtask

	// Initialises the module, loads the pointer and sets the gate.
	task automatic start(input stseq_ptr_t p, input logic g);
	begin
		@(posedge clk);
		module_init           <= 1'h1;
		external_trigger_gate <= 1'h0;
		@(posedge clk);
		module_init           <= 1'h0;
		level_pointer_load    <= 1'h1;
		level_pointer_value   <= p;
		@(posedge clk);
		level_pointer_load    <= 1'h0;
		external_trigger_gate <= g;
	end
	endtask

	// Presents one word for a single cycle and checks the module match.
	task automatic pmatch(input logic [2:0] m, input logic x, input logic se);
	begin
		@(posedge clk);
		byte_match     <= m;
		own_match      <= x;
		store_enable_n <= se;
		@(posedge clk);
		byte_match     <= 3'h0;
		@(negedge clk);
		bit_is(module_match_out, &m);
	end
	endtask

	task automatic restart(input logic pm, input logic se);
	begin
		@(posedge clk);
		restart_word          <= 1'h1;
		paired_qualifier_mode <= pm;
		store_enable_n        <= se;
		@(posedge clk);
		restart_word          <= 1'h0;
		paired_qualifier_mode <= 1'h0;
		store_enable_n        <= 1'h0;
	end
	endtask

	task automatic step_once;
	begin
		@(posedge clk);
		manual_step_enable_n <= 1'h0;
		manual_step_clock    <= ~manual_step_clock;
		settle(6);
	end
	endtask

	task automatic complete_run;
	begin
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	// Level 0: one hit, sync, timer. Level 1: last, fifteen absences.
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		load(4'h0, 4'hF, ~12'h001);
		load(4'h1, 4'h0, ~12'h00F);
		for (int i = 2; i < 16; i++)
			load(4'(i), 4'h9, ~12'h002);
		@(posedge clk);
		ctl_wr <= 1'h0;
		occ_wr <= 1'h0;
		start(4'h0, 1'h0);
		settle(1);
		bit_is(timer_action, 1'h1);
		pmatch(3'h3, 1'h1, 1'h0);
		pmatch(3'h7, 1'h1, 1'h0);
		settle(4);
		cnt_is(n_adv, 0);
		@(posedge clk);
		external_trigger_gate <= 1'h1;
		pmatch(3'h7, 1'h1, 1'h1);
		pmatch(3'h7, 1'h0, 1'h0);
		settle(4);
		cnt_is(n_adv, 0);
		pmatch(3'h7, 1'h1, 1'h0);
		settle(4);
		cnt_is(n_adv, 1);
		ptr_is(level_pointer, 4'h1);
		cnt_is(n_sync, 1);
		bit_is(timer_action, 1'h0);
		settle(40);
		bit_is(trigger_event_out, 1'h1);
		ptr_is(level_pointer, 4'h1);
		cnt_is(n_sync, 1);
		bit_is(event_line, 1'h1);
		bit_is(acquisition_hold_out, 1'h0);
		bit_is(acquisition_hold_oe, 1'h1);
		@(posedge clk);
		trigger_output_disable_n <= 1'h0;
		settle(2);
		bit_is(trigger_event_oe, 1'h0);
		bit_is(acquisition_hold_oe, 1'h0);
		@(posedge clk);
		trigger_output_disable_n <= 1'h1;
		start(4'h1, 1'h1);
		trigger_inhibit_n <= 1'h0;
		settle(40);
		bit_is(trigger_event_out, 1'h0);
		@(posedge clk);
		store_enable_n         <= 1'h1;
		qualifier_trigger_word <= 1'h1;
		settle(4);
		bit_is(trigger_event_out, 1'h0);
		@(posedge clk);
		store_enable_n         <= 1'h0;
		qualifier_trigger_word <= 1'h0;
		@(posedge clk);
		qualifier_trigger_word <= 1'h1;
		settle(2);
		bit_is(trigger_event_out, 1'h0);
		settle(1);
		bit_is(trigger_event_out, 1'h1);
		@(posedge clk);
		qualifier_trigger_word <= 1'h0;
		trigger_inhibit_n      <= 1'h1;
		restart(1'h1, 1'h0);
		restart(1'h0, 1'h1);
		settle(3);
		ptr_is(level_pointer, 4'h1);
		cnt_is(n_rel + n_clr, 0);
		restart(1'h0, 1'h0);
		settle(0);
		ptr_is(level_pointer, 4'h0);
		settle(3);
		cnt_is(n_rel, 1);
		cnt_is(n_clr, 1);
		bit_is(counter_cleared_flag, 1'h1);
		@(posedge clk);
		cleared_flag_preset  <= 1'h1;
		counter_clear_enable <= 1'h0;
		@(posedge clk);
		cleared_flag_preset  <= 1'h0;
		settle(2);
		bit_is(counter_cleared_flag, 1'h0);
		restart(1'h0, 1'h0);
		settle(3);
		cnt_is(n_rel, 2);
		cnt_is(n_clr, 1);
		bit_is(counter_cleared_flag, 1'h0);
		step_once();
		ptr_is(level_pointer, 4'h1);
		step_once();
		ptr_is(level_pointer, 4'h1);
		start(4'h2, 1'h1);
		step_once();
		ptr_is(level_pointer, 4'h3);
		pmatch(3'h7, 1'h1, 1'h0);
		settle(4);
		ptr_is(level_pointer, 4'h3);
		pmatch(3'h7, 1'h1, 1'h0);
		settle(4);
		ptr_is(level_pointer, 4'h4);
		cnt_is(n_sync, 1);
		@(posedge clk);
		acquisition_stop      <= 1'h1;
		external_trigger_gate <= 1'h0;
		@(posedge clk);
		acquisition_stop      <= 1'h0;
		pmatch(3'h7, 1'h1, 1'h0);
		pmatch(3'h7, 1'h1, 1'h0);
		settle(4);
		ptr_is(level_pointer, 4'h4);
		complete_run();
	end
endmodule
